//--- sdd_decoder.sv
`timescale 1ns/100ps
module sdd_decoder (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         link_sclk,
  input  wire logic         sync_n,
  input  wire logic         serial_data_input,
  output logic              sdo,
  output logic [15:0]       code_a,
  output logic [15:0]       code_b,
  output logic [2:0]        range_a,
  output logic [2:0]        range_b,
  output logic              frame_done,
  output logic              frame_ignored
);
  import sdd_pkg::*;

  sdd_frame_t  link_word;
  logic        link_word_tgl;
  logic        link_over_tgl;
  sdd_frame_t  readback_reg;
  logic [2:0]  sync_s;
  logic        sync_d_reg;
  logic        word_prev_reg;
  logic        over_prev_reg;
  logic        word_new;
  logic        over_new;
  logic        close;
  logic        long_drop;
  sdd_frame_t  frame_reg;
  sdd_state_t  state_reg;
  sdd_state_t  state_next;
  logic        hit_a;
  logic        hit_b;
  logic        chan_ok;
  logic        range_ok;
  logic        do_write_code;
  logic        do_write_range;
  logic        do_read;
  logic [15:0] read_value;

  sdd_link_rx u_link (
    .link_sclk         (link_sclk),
    .rst_n             (rst_n),
    .sync_n            (sync_n),
    .serial_data_input (serial_data_input),
    .readback_word     (readback_reg),
    .word_reg          (link_word),
    .word_tgl_reg      (link_word_tgl),
    .over_tgl_reg      (link_over_tgl),
    .sdo_reg           (sdo)
  );

  sdd_sync2 #(
    .WIDTH     (3),
    .RESET_VAL (3'h4)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in ({sync_n, link_word_tgl, link_over_tgl}),
    .sync_out (sync_s)
  );

  assign word_new = sync_s[1] ^ word_prev_reg;
  assign over_new = sync_s[0] ^ over_prev_reg;
  assign close    = sync_s[2] & ~sync_d_reg;

  // 25th bit may cross with the word
  assign long_drop = over_new & ((state_reg == ST_OPEN) |
                                 ((state_reg == ST_IDLE) & word_new));

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync_d_reg    <= 1'b1;
      word_prev_reg <= 1'b0;
      over_prev_reg <= 1'b0;
    end else begin
      sync_d_reg    <= sync_s[2];
      word_prev_reg <= sync_s[1];
      over_prev_reg <= sync_s[0];
    end
  end

  // word is stable once its toggle has crossed
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      frame_reg <= '0;
    end else if (word_new) begin
      frame_reg <= link_word;
    end
  end

  // wait for close after full word
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (word_new & over_new) begin
          state_next = ST_IDLE;
        end else if (word_new & close) begin
          state_next = ST_EXEC;
        end else if (word_new) begin
          state_next = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (over_new) begin
          state_next = ST_IDLE;
        end else if (close) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hit_a    = (frame_reg.channel_address == CHAN_A) |
                    (frame_reg.channel_address == CHAN_BOTH);
  assign hit_b    = (frame_reg.channel_address == CHAN_B) |
                    (frame_reg.channel_address == CHAN_BOTH);
  assign chan_ok  = hit_a | hit_b;
  assign range_ok = frame_reg.data[2:0] <= RANGE_BI_10P8;

  assign do_write_code  = (state_reg == ST_EXEC) & ~frame_reg.rw & chan_ok &
                          (frame_reg.register_select == REG_DAC);
  assign do_write_range = (state_reg == ST_EXEC) & ~frame_reg.rw & chan_ok & range_ok &
                          (frame_reg.register_select == REG_RANGE);
  assign do_read        = (state_reg == ST_EXEC) & frame_reg.rw & chan_ok &
                          ((frame_reg.register_select == REG_DAC) |
                           (frame_reg.register_select == REG_RANGE));

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      code_a <= CODE_RESET;
      code_b <= CODE_RESET;
    end else if (do_write_code) begin
      if (hit_a) begin
        code_a <= frame_reg.data & CODE_MASK;
      end
      if (hit_b) begin
        code_b <= frame_reg.data & CODE_MASK;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      range_a <= RANGE_RESET;
      range_b <= RANGE_RESET;
    end else if (do_write_range) begin
      if (hit_a) begin
        range_a <= frame_reg.data[2:0];
      end
      if (hit_b) begin
        range_b <= frame_reg.data[2:0];
      end
    end
  end

  // both-channel read returns channel a
  always_comb begin
    read_value = 16'h0000;
    if (frame_reg.register_select == REG_DAC) begin
      read_value = hit_a ? code_a : code_b;
    end else begin
      read_value = {13'h0000, (hit_a ? range_a : range_b)};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      readback_reg <= '0;
    end else if (do_read) begin
      readback_reg <= {frame_reg.rw, 1'b0, frame_reg.register_select,
                       frame_reg.channel_address, read_value};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      frame_done    <= 1'b0;
      frame_ignored <= 1'b0;
    end else begin
      frame_done    <= do_write_code | do_write_range | do_read;
      frame_ignored <= ((state_reg == ST_EXEC) &
                        ~(do_write_code | do_write_range | do_read)) |
                       long_drop;
    end
  end

endmodule : sdd_decoder

//--- sdd_pkg.sv
package sdd_pkg;

  localparam int          FRAME_BITS     = 24;
  localparam int          DATA_BITS      = 16;
  localparam int          RANGE_BITS     = 3;
  // 16, 14 or 12: the code stays left-justified in the data field
  localparam int          DAC_RESOLUTION = 16;

  localparam logic [15:0] CODE_MASK      = 16'(16'hffff << (DATA_BITS - DAC_RESOLUTION));

  localparam logic [2:0]  REG_DAC        = 3'h0;
  localparam logic [2:0]  REG_RANGE      = 3'h1;
  localparam logic [2:0]  REG_POWER      = 3'h2;
  localparam logic [2:0]  REG_CTRL       = 3'h3;

  localparam logic [2:0]  CHAN_A         = 3'h0;
  localparam logic [2:0]  CHAN_B         = 3'h2;
  localparam logic [2:0]  CHAN_BOTH      = 3'h4;

  localparam logic [2:0]  RANGE_UNI_5    = 3'h0;
  localparam logic [2:0]  RANGE_UNI_10   = 3'h1;
  localparam logic [2:0]  RANGE_UNI_10P8 = 3'h2;
  localparam logic [2:0]  RANGE_BI_5     = 3'h3;
  localparam logic [2:0]  RANGE_BI_10    = 3'h4;
  localparam logic [2:0]  RANGE_BI_10P8  = 3'h5;

  localparam logic [15:0] CODE_RESET     = 16'h0000;
  localparam logic [2:0]  RANGE_RESET    = 3'h0;

  // bit counter: last bit of a full frame, full frame, one bit too many
  localparam logic [4:0]  CNT_LAST       = 5'h17;
  localparam logic [4:0]  CNT_FULL       = 5'h18;
  localparam logic [4:0]  CNT_OVER       = 5'h19;
  localparam logic [4:0]  CNT_RESET      = 5'h00;

  typedef struct packed {
    logic        rw;
    logic        zero;
    logic [2:0]  register_select;
    logic [2:0]  channel_address;
    logic [15:0] data;
  } sdd_frame_t;

  typedef enum {
    ST_IDLE,
    ST_OPEN,
    ST_EXEC
  } sdd_state_t;

endpackage : sdd_pkg

//--- sdd_sync2.sv
`timescale 1ns/100ps
module sdd_sync2 #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : sdd_sync2

//--- sdd_link_rx.sv
`timescale 1ns/100ps
module sdd_link_rx (
  input  wire logic              link_sclk,
  input  wire logic              rst_n,
  input  wire logic              sync_n,
  input  wire logic              serial_data_input,
  input  wire sdd_pkg::sdd_frame_t readback_word,
  output sdd_pkg::sdd_frame_t    word_reg,
  output logic                   word_tgl_reg,
  output logic                   over_tgl_reg,
  output logic                   sdo_reg
);
  import sdd_pkg::*;

  logic [4:0]  cnt_reg;
  logic [23:0] shift_reg;
  logic [23:0] shift_next;

  assign shift_next = {shift_reg[22:0], serial_data_input};

  // frame select high ends the frame even with the clock stopped
  always_ff @(posedge link_sclk or posedge sync_n) begin
    if (sync_n) begin
      cnt_reg <= CNT_RESET;
    end else if (cnt_reg != CNT_OVER) begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge link_sclk) begin
    shift_reg <= shift_next;
  end

  always_ff @(posedge link_sclk) begin
    if (cnt_reg == CNT_LAST) begin
      word_reg <= shift_next;
    end
  end

  always_ff @(posedge link_sclk or negedge rst_n) begin
    if (!rst_n) begin
      word_tgl_reg <= 1'b0;
      over_tgl_reg <= 1'b0;
    end else begin
      if (cnt_reg == CNT_LAST) begin
        word_tgl_reg <= ~word_tgl_reg;
      end
      if (cnt_reg == CNT_FULL) begin
        over_tgl_reg <= ~over_tgl_reg;
      end
    end
  end

  // readback word only changes between frames
  always_ff @(posedge link_sclk or posedge sync_n) begin
    if (sync_n) begin
      sdo_reg <= 1'b0;
    end else if (cnt_reg < CNT_FULL) begin
      sdo_reg <= readback_word[CNT_LAST - cnt_reg];
    end else begin
      sdo_reg <= 1'b0;
    end
  end

endmodule : sdd_link_rx

//--- sdd_decoder_chk.sv
`timescale 1ns/100ps
module sdd_decoder_chk
  import sdd_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        link_sclk,
  input wire logic        sync_n,
  input wire logic        serial_data_input,
  input wire logic        sdo,
  input wire logic [15:0] code_a,
  input wire logic [15:0] code_b,
  input wire logic [2:0]  range_a,
  input wire logic [2:0]  range_b,
  input wire logic        frame_done,
  input wire logic        frame_ignored
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_upd;
    !$stable({code_a, code_b, range_a, range_b});
  endsequence
  sequence s_closed;
    $past(sync_n, 2) && $past(sync_n, 3);
  endsequence
  a_upd_closed: assert property (s_upd |-> s_closed)
    else $error("update before frame close");
  a_upd_done: assert property (s_upd |-> ##[0:1] frame_done)
    else $error("update without done pulse");
  a_ign_quiet: assert property (frame_ignored |-> !frame_done)
    else $error("done and ignored together");
  a_ign_stable: assert property (frame_ignored |-> $stable({code_a, code_b, range_a, range_b}))
    else $error("ignored frame changed state");
  a_done_pulse: assert property ($rose(frame_done) |=> !frame_done)
    else $error("done longer than one cycle");
  a_code_mask: assert property (((code_a | code_b) & ~CODE_MASK) == 16'h0000)
    else $error("code low bits not ignored");
  a_range_legal: assert property (range_a <= RANGE_BI_10P8 && range_b <= RANGE_BI_10P8)
    else $error("undefined range stored");
  a_sdo_idle: assert property (sync_n && $past(sync_n) |-> !sdo)
    else $error("readback outside frame");
endmodule : sdd_decoder_chk

bind sdd_decoder sdd_decoder_chk i_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .link_sclk(link_sclk), .sync_n(sync_n), .serial_data_input(serial_data_input),
  .sdo(sdo), .code_a(code_a), .code_b(code_b), .range_a(range_a),
  .range_b(range_b), .frame_done(frame_done), .frame_ignored(frame_ignored));

//--- sdd_host.sv
`timescale 1ns/100ps
module sdd_host
  import sdd_pkg::*;
(
  output logic      link_sclk,
  output logic      sync_n,
  output logic      serial_data_input,
  input  wire logic sdo
);
  logic [23:0] rx;
  initial begin
    link_sclk         = 1'b0;
    sync_n            = 1'b0;
    serial_data_input = 1'b1;
    rx                = 24'h000000;
    // frame select edge clears the link bit counter and sdo once all processes wait
    #1 sync_n = 1'b1;
  end
  task automatic send(input sdd_frame_t f, input int extra);
    int n;
    n = 24 + extra;
    sync_n = 1'b0;
    // link edges kept off the system clock edges
    #5.3;
    for (int i = 0; i < n; i++) begin
      serial_data_input = (i == 1) ? 1'b0 : (i < 24) ? f[23-i] : ~f[0];
      #3 link_sclk = 1'b1;
      #3 link_sclk = 1'b0;
      rx = {rx[22:0], sdo};
    end
    #5 sync_n = 1'b1;
    serial_data_input = ~serial_data_input;
  endtask : send
endmodule : sdd_host

//--- tb.sv
`timescale 1ns/100ps
module tb;
  import sdd_pkg::*;
  typedef struct packed {
    sdd_frame_t  f;
    logic [37:0] q;
    logic        ig;
  } sdd_row_t;
  localparam logic [37:0] MSK = {CODE_MASK, CODE_MASK, 6'h3f};
  localparam logic [31:0] C8 = 32'h80018001;
  localparam sdd_row_t ROWS [12] = '{
    '{{2'h0, REG_DAC, CHAN_A, 16'h1234}, {16'h1234, 16'h0000, 6'h00}, 1'b0},
    '{{2'h0, REG_DAC, CHAN_B, 16'habcd}, {16'h1234, 16'habcd, 6'h00}, 1'b0},
    '{{2'h0, REG_DAC, CHAN_BOTH, 16'h8001}, {C8, 6'h00}, 1'b0},
    '{{2'h0, REG_RANGE, CHAN_A, 16'hfff9}, {C8, RANGE_UNI_10, RANGE_UNI_5}, 1'b0},
    '{{2'h0, REG_RANGE, CHAN_B, 16'h0002}, {C8, RANGE_UNI_10, RANGE_UNI_10P8}, 1'b0},
    '{{2'h0, REG_RANGE, CHAN_BOTH, 16'h0000}, {C8, RANGE_UNI_5, RANGE_UNI_5}, 1'b0},
    '{{2'h0, REG_RANGE, CHAN_BOTH, 16'h0003}, {C8, RANGE_BI_5, RANGE_BI_5}, 1'b0},
    '{{2'h0, REG_RANGE, CHAN_A, 16'h0004}, {C8, RANGE_BI_10, RANGE_BI_5}, 1'b0},
    '{{2'h0, REG_RANGE, CHAN_B, 16'hfffd}, {C8, RANGE_BI_10, RANGE_BI_10P8}, 1'b0},
    '{{2'h0, REG_RANGE, CHAN_A, 16'h0006}, {C8, RANGE_BI_10, RANGE_BI_10P8}, 1'b1},
    '{{2'h0, REG_DAC, 3'h1, 16'h5555}, {C8, RANGE_BI_10, RANGE_BI_10P8}, 1'b1},
    '{{2'h0, REG_POWER, CHAN_A, 16'h0001}, {C8, RANGE_BI_10, RANGE_BI_10P8}, 1'b1}};
  logic        ref_clk = 1'b0;
  logic        rst_n;
  logic        link_sclk;
  logic        sync_n;
  logic        serial_data_input;
  logic        sdo;
  logic [15:0] code_a;
  logic [15:0] code_b;
  logic [2:0]  range_a;
  logic [2:0]  range_b;
  logic        frame_done;
  logic        frame_ignored;
  logic [37:0] st;
  logic        d;
  logic        ig;
  int          n_errors;
  int          checks;
  assign st = {code_a, code_b, range_a, range_b};
  always #4 ref_clk = ~ref_clk;
  sdd_host i_sdd_host (.link_sclk(link_sclk), .sync_n(sync_n),
    .serial_data_input(serial_data_input), .sdo(sdo));
  sdd_decoder i_sdd_decoder (.ref_clk(ref_clk), .rst_n(rst_n), .link_sclk(link_sclk),
    .sync_n(sync_n), .serial_data_input(serial_data_input), .sdo(sdo),
    .code_a(code_a), .code_b(code_b), .range_a(range_a), .range_b(range_b),
    .frame_done(frame_done), .frame_ignored(frame_ignored));
  task automatic chk(input string nm, input logic [37:0] seen, input logic [37:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic run(input sdd_frame_t f, input int extra);
    d  = 1'b0;
    ig = 1'b0;
    @(negedge ref_clk);
    i_sdd_host.send(f, extra);
    repeat (12) begin
      @(negedge ref_clk);
      d  = d | frame_done;
      ig = ig | frame_ignored;
    end
  endtask : run
  task automatic wrap_up();
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    #20000;
    n_errors++;
    wrap_up();
  end
  initial begin
    rst_n    = 1'b1;
    n_errors = 0;
    checks   = 0;
    // reset edge once every process waits
    #1 rst_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    chk("reset", st, {CODE_RESET, CODE_RESET, RANGE_RESET, RANGE_RESET});
    repeat (3) @(negedge ref_clk);
    for (int r = 0; r < 12; r++) begin
      run(ROWS[r].f, 0);
      chk("regs", st, ROWS[r].q & MSK);
      chk("pulse", 38'({d, ig}), 38'({~ROWS[r].ig, ROWS[r].ig}));
    end
    run({2'h0, REG_DAC, CHAN_A, 16'h0f0f}, -1);
    chk("short", st, ROWS[11].q & MSK);
    chk("short pulse", 38'({d, ig}), 38'h0);
    run({2'h0, REG_DAC, CHAN_A, 16'h0f0f}, 1);
    chk("long", st, ROWS[11].q & MSK);
    chk("long pulse", 38'({d, ig}), 38'h1);
    run({2'h2, REG_DAC, CHAN_B, 16'h0000}, 0);
    run({2'h2, REG_RANGE, CHAN_A, 16'h0000}, 0);
    chk("read code", 38'(i_sdd_host.rx[15:0]), 38'(16'h8001 & CODE_MASK));
    chk("read pulse", 38'({d, ig}), 38'h2);
    run({2'h0, REG_DAC, CHAN_A, 16'h00f0}, 0);
    chk("read range", 38'(i_sdd_host.rx[15:0]), 38'({13'h0, RANGE_BI_10}));
    chk("after read", st, {16'h00f0, C8[15:0], RANGE_BI_10, RANGE_BI_10P8} & MSK);
    rst_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    chk("reset again", st, {CODE_RESET, CODE_RESET, RANGE_RESET, RANGE_RESET});
    wrap_up();
  end
endmodule : tb
